// ===== rtl/boot_pkt_pkg.sv
// Package of constants and types for the boot loader packet command block.
package boot_pkt_pkg;
   localparam logic [7:0] ACK_BYTE      = 8'hcc;
   localparam logic [7:0] NAK_BYTE      = 8'h33;
   localparam logic [7:0] SYNC_BYTE     = 8'h55;
   localparam logic [7:0] CMD_PROBE     = 8'h20;
   localparam logic [7:0] CMD_SETUP     = 8'h21;
   localparam logic [7:0] CMD_JUMP      = 8'h22;
   localparam logic [7:0] CMD_QUERY     = 8'h23;
   localparam logic [7:0] CMD_CHUNK     = 8'h24;
   localparam logic [7:0] CMD_RESTART   = 8'h25;
   localparam logic [7:0] LEN_PROBE     = 8'h03;
   localparam logic [7:0] LEN_SETUP     = 8'h0b;
   localparam logic [7:0] LEN_JUMP      = 8'h07;
   localparam logic [7:0] LEN_RESTART   = 8'h03;
   localparam logic [7:0] LEN_QUERY_RSP = 8'h03;
   localparam logic [7:0] MAX_CHUNK     = 8'h08;
   localparam logic [7:0] STAT_SUCCESS  = 8'h40;
   localparam logic [7:0] STAT_UNKNOWN  = 8'h41;
   localparam logic [7:0] STAT_INVALID  = 8'h42;
   localparam logic [7:0] STAT_FLASH    = 8'h43;
   localparam logic [7:0] STAT_RESET    = 8'h00;

   // One byte on the serial link.
   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } byte_beat_type;

   // Request to the flash engine.
   typedef struct packed {
      logic        erase;
      logic        write;
      logic [31:0] addr;
      logic [31:0] size;
      logic [7:0]  data;
   } flash_req_type;
endpackage : boot_pkt_pkg

// ===== rtl/boot_pkt_cmd.sv
// Packet framing and command decoding for a serial boot loader.
// Function
// - Packet starts with length byte counting length, sum and payload.
// - Second byte is payload sum, payload bytes only.
// - Reply 0xcc on good reception, 0x33 on failure.
// - Acknowledge reflects framing only, never command validity.
// - Outgoing packet may be led by zeros; first non-zero is length.
// - After length byte, rest of packet follows without gaps.
// - Zero bytes ignored; first non-zero byte is the host answer.
// - First payload byte is the command; rest are parameters.
// - Probe 0x20, three bytes, sets status to success.
// - Query 0x23 returns one-byte packet with previous status.
// - Setup 0x21, eleven bytes: address then count, MSB first.
// - Setup erases the region before the acknowledge is sent.
// - Chunk 0x24 writes at current address, then advances it.
// - Programming ends when announced byte count is received.
// - Rejected chunk leaves the programming address unchanged.
// - Jump 0x22, seven bytes, address MSB first; acknowledge first.
// - Restart 0x25, three bytes; acknowledge before the reset.
// - Async link bytes are eight data bits, no parity, one stop.
// - Two 0x55 bytes precede packets; device answers 0xcc.
// - Synchronous link host is clock master, polarity 1, phase 1.
`timescale 1ns/1ps
`default_nettype none
module boot_pkt_cmd
   import boot_pkt_pkg::*;
#(
   parameter int CHUNK_BYTES = 8
)(
   // Clock and reset.
   input  wire logic                      REF_CLK_I,
   input  wire logic                      RST_B_I,
   // Received bytes from the serial layer.
   input  wire boot_pkt_pkg::byte_beat_type RX_I,
   // Byte sink ready for a transmit byte.
   input  wire logic                      TX_READY_I,
   // Serial layer selects the asynchronous link needing a sync pattern.
   input  wire logic                      ASYNC_LINK_I,
   // Flash engine handshake.
   input  wire logic                      FLASH_DONE_I,
   input  wire logic                      FLASH_ERR_I,
   // Transmitted bytes to the serial layer.
   output logic                           TX_VALID_O,
   output logic [7:0]                     TX_DATA_O,
   // Flash engine requests.
   output boot_pkt_pkg::flash_req_type    FLASH_REQ_O,
   // Control handover.
   output logic                           JUMP_O,
   output logic [31:0]                    JUMP_ADDR_O,
   output logic                           RESTART_O,
   output logic [7:0]                     STATUS_O
);
   import boot_pkt_pkg::*;

   typedef enum {
      ST_SYNC0, ST_SYNC1, ST_LEN, ST_SUM, ST_PAY, ST_EXEC, ST_ERASE,
      ST_WRITE, ST_ACK, ST_RSP, ST_RSP_WAIT, ST_DONE
   } state_type;

   state_type   state_ff, nxt_state;
   logic [7:0]  len_ff, sum_ff, acc_ff, idx_ff, status_ff, rsp_idx_ff;
   logic [7:0]  pay_ff [0:10];
   logic [31:0] addr_ff, left_ff;
   logic [7:0]  wr_idx_ff;
   logic        good_ff, after_ack_ff, rsp_pend_ff;
   logic [1:0]  after_kind_ff;

   // Incoming byte qualifiers shared by several states.
   // Each beat is one whole eight-bit character from the serial layer.
   wire        rx_nz    = RX_I.valid && (RX_I.data != 8'h00);
   wire        rx_any   = RX_I.valid;
   wire [7:0]  cmd      = pay_ff[0];
   wire [7:0]  pay_cnt  = 8'(len_ff - 8'h02);
   wire [31:0] par_a    = {pay_ff[1], pay_ff[2], pay_ff[3], pay_ff[4]};
   wire [31:0] par_b    = {pay_ff[5], pay_ff[6], pay_ff[7], pay_ff[8]};
   wire        len_ok   = (RX_I.data >= 8'h03) && (RX_I.data <= 8'h0d);
   wire [7:0]  chunk_n  = 8'(pay_cnt - 8'h01);
   wire        tx_take  = TX_VALID_O && TX_READY_I;
   // A packet is good when its length was legal and its sum matches.
   wire        rx_good  = good_ff && (acc_ff == sum_ff);
   // Next write address and index, so a waiting request never moves.
   wire        wr_step  = (state_ff == ST_WRITE) && FLASH_DONE_I;
   wire [31:0] req_addr = wr_step ? 32'(addr_ff + 32'h1) : addr_ff;
   wire [7:0]  req_idx  = (state_ff == ST_EXEC) ? 8'h00
                        : wr_step ? 8'(wr_idx_ff + 8'h01) : wr_idx_ff;

   // Status after a command, from its code and length, and for a chunk also the remaining count.
   function automatic logic [7:0] cmd_status(input logic [7:0] c,
                                             input logic [7:0] l,
                                             input logic [31:0] rem);
      if (c == CMD_PROBE || c == CMD_QUERY)
         cmd_status = (l == LEN_PROBE) ? STAT_SUCCESS : STAT_INVALID;
      else if (c == CMD_SETUP)
         cmd_status = (l == LEN_SETUP) ? STAT_SUCCESS : STAT_INVALID;
      else if (c == CMD_JUMP)
         cmd_status = (l == LEN_JUMP) ? STAT_SUCCESS : STAT_INVALID;
      else if (c == CMD_RESTART)
         cmd_status = (l == LEN_RESTART) ? STAT_SUCCESS : STAT_INVALID;
      else if (c == CMD_CHUNK)
         cmd_status = (l > 8'h03 && l <= 8'(MAX_CHUNK + 8'h03)
                       && rem != 32'h0) ? STAT_SUCCESS : STAT_INVALID;
      else
         cmd_status = STAT_UNKNOWN;
   endfunction : cmd_status

   wire [7:0] exec_stat = cmd_status(cmd, len_ff, left_ff);

   // Next state of the packet sequencer.
   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         ST_SYNC0: if (rx_any && RX_I.data == SYNC_BYTE) nxt_state = ST_SYNC1;
         ST_SYNC1: if (rx_any)
                      nxt_state = (RX_I.data == SYNC_BYTE) ? ST_ACK : ST_SYNC0;
         ST_LEN:   if (rx_nz) nxt_state = len_ok ? ST_SUM : ST_ACK;
         ST_SUM:   if (rx_any) nxt_state = ST_PAY;
         ST_PAY:   if (rx_any && idx_ff == 8'(pay_cnt - 8'h01))
                      nxt_state = ST_EXEC;
         ST_EXEC:  if (!rx_good) nxt_state = ST_ACK;
                   else if (cmd == CMD_SETUP && exec_stat == STAT_SUCCESS)
                      nxt_state = ST_ERASE;
                   else if (cmd == CMD_CHUNK && exec_stat == STAT_SUCCESS)
                      nxt_state = ST_WRITE;
                   else nxt_state = ST_ACK;
         ST_ERASE: if (FLASH_DONE_I) nxt_state = ST_ACK;
         ST_WRITE: if (FLASH_DONE_I && (wr_idx_ff == 8'(chunk_n - 8'h01)
                      || left_ff == 32'h1 || FLASH_ERR_I))
                      nxt_state = ST_ACK;
         ST_ACK:   if (tx_take)
                      nxt_state = rsp_pend_ff ? ST_RSP
                                : (after_kind_ff != 2'd0) ? ST_DONE : ST_LEN;
         ST_RSP:   if (tx_take && rsp_idx_ff == 8'h02) nxt_state = ST_RSP_WAIT;
         ST_RSP_WAIT: if (rx_nz) nxt_state = ST_LEN;
         ST_DONE:  nxt_state = ST_DONE;
         default:  nxt_state = ST_LEN;
      endcase
   end

   // Sequencer state and packet capture.
   always_ff @(posedge REF_CLK_I or negedge RST_B_I)
   begin
      if (!RST_B_I)
      begin
         state_ff <= ST_SYNC0;
         len_ff <= 8'h00;
         sum_ff <= 8'h00;
         acc_ff <= 8'h00;
         idx_ff <= 8'h00;
         good_ff <= 1'b0;
      end
      else
      begin
         // A synchronous link needs no sync pattern; the host clocks it.
         if (state_ff == ST_SYNC0 && !ASYNC_LINK_I)
            state_ff <= ST_LEN;
         else
            state_ff <= nxt_state;
         if (state_ff == ST_LEN && rx_nz)
         begin
            len_ff <= RX_I.data;
            good_ff <= len_ok;
            acc_ff <= 8'h00;
            idx_ff <= 8'h00;
         end
         if (state_ff == ST_SUM && rx_any)
            sum_ff <= RX_I.data;
         if (state_ff == ST_PAY && rx_any)
         begin
            acc_ff <= 8'(acc_ff + RX_I.data);
            idx_ff <= 8'(idx_ff + 8'h01);
         end
         if (state_ff == ST_EXEC)
            good_ff <= good_ff && (acc_ff == sum_ff);
      end
   end

   // Payload store; byte zero is the command code.
   always_ff @(posedge REF_CLK_I)
   begin
      if (state_ff == ST_PAY && rx_any && idx_ff < 8'd11)
         pay_ff[4'(idx_ff)] <= RX_I.data;
   end

   // Command effects: status, programming window, handover.
   always_ff @(posedge REF_CLK_I or negedge RST_B_I)
   begin
      if (!RST_B_I)
      begin
         status_ff <= STAT_RESET;
         addr_ff <= 32'h0;
         left_ff <= 32'h0;
         wr_idx_ff <= 8'h00;
         rsp_pend_ff <= 1'b0;
         after_kind_ff <= 2'd0;
         JUMP_ADDR_O <= 32'h0;
      end
      else
      begin
         if (state_ff == ST_EXEC && good_ff && acc_ff == sum_ff
             && cmd != CMD_QUERY)
         begin
            status_ff <= exec_stat;
            wr_idx_ff <= 8'h00;
            if (cmd == CMD_SETUP && exec_stat == STAT_SUCCESS)
            begin
               addr_ff <= par_a;
               left_ff <= par_b;
            end
            if (cmd == CMD_JUMP && exec_stat == STAT_SUCCESS)
            begin
               JUMP_ADDR_O <= par_a;
               after_kind_ff <= 2'd1;
            end
            if (cmd == CMD_RESTART && exec_stat == STAT_SUCCESS)
               after_kind_ff <= 2'd2;
         end
         if (state_ff == ST_EXEC && good_ff && acc_ff == sum_ff
             && cmd == CMD_QUERY)
            rsp_pend_ff <= 1'b1;
         if (state_ff == ST_ERASE && FLASH_DONE_I && FLASH_ERR_I)
            status_ff <= STAT_FLASH;
         if (state_ff == ST_WRITE && FLASH_DONE_I)
         begin
            addr_ff <= addr_ff + 32'h1;
            left_ff <= left_ff - 32'h1;
            wr_idx_ff <= 8'(wr_idx_ff + 8'h01);
            if (FLASH_ERR_I)
               status_ff <= STAT_FLASH;
         end
         if (state_ff == ST_ACK && tx_take)
            rsp_pend_ff <= 1'b0;
      end
   end

   // Byte sequencing of the reply and of the status packet.
   always_ff @(posedge REF_CLK_I or negedge RST_B_I)
   begin
      if (!RST_B_I)
         rsp_idx_ff <= 8'h00;
      else if (state_ff == ST_ACK)
         rsp_idx_ff <= 8'h00;
      else if (state_ff == ST_RSP && tx_take)
         rsp_idx_ff <= 8'(rsp_idx_ff + 8'h01);
   end

   // Transmit byte selection: acknowledge, then length, sum, status.
   // A byte is fixed when it is launched and held while it waits.
   wire [7:0] ack_byte = (state_ff == ST_ACK) ? TX_DATA_O
                         : (state_ff == ST_SYNC1 || state_ff == ST_ERASE
                            || state_ff == ST_WRITE
                            || (state_ff == ST_EXEC && rx_good))
                         ? ACK_BYTE : NAK_BYTE;
   wire [7:0] rsp_byte = (state_ff != ST_RSP) ? LEN_QUERY_RSP
                         : tx_take ? status_ff : TX_DATA_O;
   wire       tx_nxt_v = (nxt_state == ST_ACK) || (nxt_state == ST_RSP);
   wire [7:0] tx_nxt_d = (nxt_state == ST_ACK) ? ack_byte : rsp_byte;

   // Flash request selection from the sequencer state.
   flash_req_type nxt_req;
   always_comb
   begin
      nxt_req = '0;
      nxt_req.erase = (nxt_state == ST_ERASE);
      nxt_req.write = (nxt_state == ST_WRITE);
      nxt_req.addr  = (nxt_state == ST_ERASE) ? par_a : req_addr;
      nxt_req.size  = par_b;
      // The data byte sits one past the command code in the store.
      nxt_req.data  = pay_ff[4'(req_idx + 8'h01)];
   end

   // Registered outputs.
   always_ff @(posedge REF_CLK_I or negedge RST_B_I)
   begin
      if (!RST_B_I)
      begin
         TX_VALID_O <= 1'b0;
         TX_DATA_O <= 8'h00;
         FLASH_REQ_O <= '0;
         JUMP_O <= 1'b0;
         RESTART_O <= 1'b0;
         STATUS_O <= 8'h00;
      end
      else
      begin
         TX_VALID_O <= tx_nxt_v && !(tx_take && nxt_state == state_ff
                                     && state_ff == ST_ACK);
         TX_DATA_O <= tx_nxt_d;
         FLASH_REQ_O <= nxt_req;
         JUMP_O <= (state_ff == ST_DONE) && (after_kind_ff == 2'd1);
         RESTART_O <= (state_ff == ST_DONE) && (after_kind_ff == 2'd2);
         STATUS_O <= status_ff;
      end
   end
endmodule : boot_pkt_cmd
`default_nettype wire

// ===== bench/boot_pkt_cmd_assertions.sv
// Port checks for the boot packet command block.
`timescale 1ns/1ps
`default_nettype none
module boot_pkt_cmd_chk
   import boot_pkt_pkg::*;
#(
   parameter int CHUNK_BYTES = 8
)(
   // Clock and reset.
   input wire logic                         REF_CLK_I,
   input wire logic                         RST_B_I,
   // Watched inputs.
   input wire boot_pkt_pkg::byte_beat_type  RX_I,
   input wire logic                         TX_READY_I,
   input wire logic                         ASYNC_LINK_I,
   input wire logic                         FLASH_DONE_I,
   input wire logic                         FLASH_ERR_I,
   // Watched outputs.
   input wire logic                         TX_VALID_O,
   input wire logic [7:0]                   TX_DATA_O,
   input wire boot_pkt_pkg::flash_req_type  FLASH_REQ_O,
   input wire logic                         JUMP_O,
   input wire logic [31:0]                  JUMP_ADDR_O,
   input wire logic                         RESTART_O,
   input wire logic [7:0]                   STATUS_O
);
   default clocking @(posedge REF_CLK_I); endclocking
   default disable iff (!RST_B_I);
   logic ack_seen_ff;
   // An acknowledge byte is taken by the sink in this cycle.
   wire logic ack_take = TX_VALID_O && TX_READY_I && TX_DATA_O == ACK_BYTE;
   // Remembers that an acknowledge has left since reset.
   always_ff @(posedge REF_CLK_I or negedge RST_B_I)
      if (!RST_B_I) ack_seen_ff <= 1'b0;
      else if (ack_take) ack_seen_ff <= 1'b1;
   a_tx_holds: assert property (
      TX_VALID_O && !TX_READY_I |=> TX_VALID_O && $stable(TX_DATA_O))
      else $error("tx byte dropped");
   a_rsp_no_gap: assert property (
      TX_VALID_O && TX_READY_I && TX_DATA_O == LEN_QUERY_RSP |=> TX_VALID_O)
      else $error("gap after reply length");
   a_erase_holds: assert property (
      FLASH_REQ_O.erase && !FLASH_DONE_I |=>
      FLASH_REQ_O.erase && $stable(FLASH_REQ_O.size))
      else $error("erase lost");
   a_erase_quiet: assert property (
      FLASH_REQ_O.erase |-> !TX_VALID_O)
      else $error("reply during erase");
   a_erase_acks: assert property (
      FLASH_REQ_O.erase && FLASH_DONE_I |->
      ##[1:2] TX_VALID_O && TX_DATA_O == ACK_BYTE)
      else $error("no setup ack");
   a_write_holds: assert property (
      FLASH_REQ_O.write && !FLASH_DONE_I |=> FLASH_REQ_O.write
      && $stable(FLASH_REQ_O.addr) && $stable(FLASH_REQ_O.data))
      else $error("write changed");
   a_one_request: assert property (
      !(FLASH_REQ_O.erase && FLASH_REQ_O.write))
      else $error("erase and write together");
   a_jump_after_ack: assert property (
      $rose(JUMP_O) |-> ack_seen_ff)
      else $error("jump before ack");
   a_jump_parks: assert property (
      JUMP_O |=> JUMP_O && $stable(JUMP_ADDR_O))
      else $error("jump not held");
   a_restart_after_ack: assert property (
      $rose(RESTART_O) |-> ack_seen_ff)
      else $error("restart before ack");
   // Main scenarios that the bench should reach.
   c_jump: cover property ($rose(JUMP_O));
   c_erase: cover property (FLASH_REQ_O.erase && FLASH_DONE_I);
   c_write: cover property (FLASH_REQ_O.write && FLASH_DONE_I);
   c_nak: cover property (TX_VALID_O && TX_READY_I && TX_DATA_O == NAK_BYTE);
endmodule : boot_pkt_cmd_chk
bind boot_pkt_cmd boot_pkt_cmd_chk #(.CHUNK_BYTES(CHUNK_BYTES)) i_chk (
   .REF_CLK_I(REF_CLK_I), .RST_B_I(RST_B_I), .RX_I(RX_I),
   .TX_READY_I(TX_READY_I), .ASYNC_LINK_I(ASYNC_LINK_I),
   .FLASH_DONE_I(FLASH_DONE_I), .FLASH_ERR_I(FLASH_ERR_I),
   .TX_VALID_O(TX_VALID_O), .TX_DATA_O(TX_DATA_O), .FLASH_REQ_O(FLASH_REQ_O),
   .JUMP_O(JUMP_O), .JUMP_ADDR_O(JUMP_ADDR_O), .RESTART_O(RESTART_O),
   .STATUS_O(STATUS_O));
`default_nettype wire

// ===== bench/host_model.sv
// Host model that frames packets for the block and collects its replies.
`timescale 1ns/1ps
`default_nettype none
module host_model
   import boot_pkt_pkg::*;
(
   // Clock.
   input  wire logic                   clk_i,
   // Link to the block.
   output boot_pkt_pkg::byte_beat_type rx_o,
   output logic                        ready_o,
   input  wire logic                   tx_valid_i,
   input  wire logic [7:0]             tx_data_i
);
   logic [7:0] got_q[$];
   logic       slow = 1'b0;
   initial rx_o = '0;
   // Sink is ready every cycle, or every other cycle when slow.
   always @(negedge clk_i) ready_o <= !slow || !ready_o;
   // Collects every byte the sink takes.
   always @(posedge clk_i)
      if (tx_valid_i && ready_o) got_q.push_back(tx_data_i);
   // One byte for one cycle; the idle data is inverted, not held.
   task automatic put(input logic [7:0] b);
      @(negedge clk_i);
      rx_o = {1'b1, b};
      @(negedge clk_i);
      rx_o = {1'b0, ~b};
   endtask : put
   // Frames a payload; bad flips the low bit of the sum.
   task automatic send(input logic [7:0] p[$], input bit bad);
      logic [7:0] s;
      s = 8'h00;
      foreach (p[i]) s += p[i]; // Sum wraps at eight bits.
      put(8'h00); // Padding byte.
      put(8'(p.size() + 2)); // Whole length.
      put(s ^ {7'h00, bad});
      foreach (p[i]) put(p[i]);
   endtask : send
   // Answers a device packet after a padding byte.
   task automatic ans(input logic [7:0] b);
      put(8'h00);
      put(b);
   endtask : ans
   // Next reply byte, skipping zeros when nz is set.
   task automatic get(output logic [7:0] b, input bit nz);
      int n;
      n = 0;
      do
      begin
         while (got_q.size() == 0 && n < 4000)
         begin
            n++;
            @(posedge clk_i);
         end
         b = (got_q.size() > 0) ? got_q.pop_front() : 8'hxx;
      end while (nz && b === 8'h00);
   endtask : get
endmodule : host_model
`default_nettype wire

// ===== bench/testbench.sv
// Self-checking bench for the boot packet command block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import boot_pkt_pkg::*;
   logic clk = 1'b0, rst_b = 1'b0, async_link = 1'b0, fdone = 1'b0;
   logic tx_ready, tx_valid, jump, restart;
   logic [7:0] tx_data, status, b;
   logic [31:0] jump_addr, ea, es;
   byte_beat_type rx;
   flash_req_type freq;
   logic [39:0] wlog[$];
   logic [7:0] d[3] = '{8'h5a, 8'ha5, 8'h3c};
   int mismatches = 0;
   int n_compared = 0;
   // System clock.
   always #10 clk = ~clk;
   boot_pkt_cmd #(.CHUNK_BYTES(8)) i_boot_pkt_cmd (
      .REF_CLK_I(clk), .RST_B_I(rst_b), .RX_I(rx), .TX_READY_I(tx_ready),
      .ASYNC_LINK_I(async_link), .FLASH_DONE_I(fdone), .FLASH_ERR_I(1'b0),
      .TX_VALID_O(tx_valid), .TX_DATA_O(tx_data), .FLASH_REQ_O(freq),
      .JUMP_O(jump), .JUMP_ADDR_O(jump_addr), .RESTART_O(restart),
      .STATUS_O(status));
   host_model host (.clk_i(clk), .rx_o(rx), .ready_o(tx_ready),
      .tx_valid_i(tx_valid), .tx_data_i(tx_data));
   // Flash stand-in: one done pulse per request, work is logged.
   always @(negedge clk) fdone <= (freq.erase || freq.write) && !fdone;
   always @(posedge clk)
      if (fdone && freq.write) wlog.push_back({freq.addr, freq.data});
      else if (fdone && freq.erase) {ea, es} <= {freq.addr, freq.size};
   task automatic chk(input logic [31:0] got, exp, input string m);
      n_compared++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask : chk
   task automatic reset(input logic a);
      @(negedge clk);
      rst_b = 1'b0;
      async_link = a;
      repeat (8) @(negedge clk);
      rst_b = 1'b1;
      repeat (2) @(negedge clk);
   endtask : reset
   task automatic cmd(input logic [7:0] p[$], input bit bad,
                      input logic [7:0] e);
      host.send(p, bad);
      host.get(b, 1'b1);
      chk(b, e, "reply byte"); // Ack or reject.
   endtask : cmd
   task automatic query(input logic [7:0] st, input logic [7:0] a);
      cmd('{CMD_QUERY}, 1'b0, ACK_BYTE); // Status query.
      host.get(b, 1'b1);
      chk(b, LEN_QUERY_RSP, "reply length"); // First non-zero.
      host.get(b, 1'b0);
      chk(b, st, "reply sum"); // Sum of payload.
      host.get(b, 1'b0);
      chk(b, st, "status code"); // Prior status.
      host.ans(a);
   endtask : query
   task automatic t_sync;
      reset(1'b1);
      host.put(8'h12); // Ignored before sync.
      host.put(SYNC_BYTE);
      host.put(SYNC_BYTE);
      host.get(b, 1'b1);
      chk(b, ACK_BYTE, "sync reply"); // Sync answer.
      cmd('{CMD_PROBE}, 1'b0, ACK_BYTE); // Probe.
      chk(status, STAT_SUCCESS, "probe status"); // Probe result.
      cmd('{CMD_PROBE}, 1'b1, NAK_BYTE); // Bad sum.
      host.put(8'h02);
      host.get(b, 1'b1);
      chk(b, NAK_BYTE, "short length"); // Too short.
      $display("sync and probe done");
   endtask : t_sync
   task automatic t_unknown;
      reset(1'b0);
      chk(status, STAT_RESET, "reset status"); // Reset status.
      host.slow = 1'b1;
      cmd('{8'h30}, 1'b0, ACK_BYTE); // Unknown code acked.
      query(STAT_UNKNOWN, NAK_BYTE); // Reply refused.
      query(STAT_UNKNOWN, ACK_BYTE); // Same query again.
      host.slow = 1'b0;
      $display("unknown and query done");
   endtask : t_unknown
   task automatic t_program;
      cmd('{CMD_SETUP, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00,
         8'h03}, 1'b0, ACK_BYTE); // Setup.
      chk(ea, 32'h00001000, "erase address"); // Address MSB first.
      chk(es, 32'h00000003, "erase size"); // Count MSB first.
      cmd('{CMD_CHUNK, d[0], d[1]}, 1'b1, NAK_BYTE); // Bad chunk.
      cmd('{CMD_CHUNK, d[0], d[1]}, 1'b0, ACK_BYTE); // Chunk.
      cmd('{CMD_CHUNK, d[2]}, 1'b0, ACK_BYTE); // Chunk.
      query(STAT_SUCCESS, ACK_BYTE); // Check.
      cmd('{CMD_CHUNK, 8'hc3}, 1'b0, ACK_BYTE); // Extra chunk.
      query(STAT_INVALID, ACK_BYTE); // Count used up.
      chk(wlog.size(), 3, "write count"); // No extra write.
      for (int i = 0; i < 3; i++)
      begin
         chk(wlog[i][39:8], 32'h00001000 + i, "write address");
         chk(wlog[i][7:0], d[i], "write data"); // Data order.
      end
      $display("program done");
   endtask : t_program
   task automatic t_handover;
      cmd('{CMD_JUMP, 8'h12, 8'h34, 8'h56, 8'h78}, 1'b0, ACK_BYTE);
      for (int n = 0; n < 20 && jump !== 1'b1; n++) @(negedge clk);
      chk(jump, 1'b1, "jump"); // Jump after ack.
      chk(jump_addr, 32'h12345678, "jump address"); // Address.
      reset(1'b0);
      cmd('{CMD_RESTART}, 1'b0, ACK_BYTE); // Restart.
      for (int n = 0; n < 20 && restart !== 1'b1; n++) @(negedge clk);
      chk(restart, 1'b1, "restart"); // Restart after ack.
      $display("jump and restart done");
   endtask : t_handover
   task automatic finish_test;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : finish_test
   // Main sequence.
   initial
   begin
      t_sync;
      t_unknown;
      t_program;
      t_handover;
      finish_test;
   end
   // Watchdog against a hang.
   initial
   begin
      #1000000;
      mismatches++;
      finish_test;
   end
endmodule : testbench
`default_nettype wire
